// [rtl/gpm_pkg.sv]
// Constants, register map and field layout for the GPIO port with pin mux
`default_nettype none
package gpm_pkg;
    localparam logic [31:0] GPM_BASE_ADDR = 32'h4000_0000;

    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_DIR = 8'h04;
    localparam logic [7:0] OFF_PULL = 8'h08;
    localparam logic [7:0] OFF_DRIVE = 8'h0C;
    localparam logic [7:0] OFF_SENSE = 8'h10;
    localparam logic [7:0] OFF_BOTH = 8'h14;
    localparam logic [7:0] OFF_POL = 8'h18;
    localparam logic [7:0] OFF_MASK = 8'h1C;
    localparam logic [7:0] OFF_GAP = 8'h20;
    localparam logic [7:0] OFF_MIS = 8'h24;
    localparam logic [7:0] OFF_ICLR = 8'h28;
    localparam logic [7:0] OFF_FUNC0 = 8'h2C;
    localparam logic [7:0] OFF_FUNC1 = 8'h30;
    localparam logic [7:0] OFF_FUNC2 = 8'h34;
    localparam logic [7:0] OFF_FUNC3 = 8'h38;
    localparam logic [7:0] OFF_SET = 8'h3C;
    localparam logic [7:0] OFF_CLR = 8'h40;
    localparam logic [7:0] OFF_CAP = 8'h44;

    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_PULL = 32'h03FF_FFFF;
    localparam logic [31:0] RST_FUNC1 = 32'h0000_0110;

    // Pin classes
    localparam logic [31:0] PULL_UP_PINS = 32'h0000_0E00;
    localparam logic [31:0] NO_PULL_PINS = 32'h0000_3000;
    localparam logic [31:0] INPUT_ONLY_PINS = 32'h0000_3000;
    localparam int WAKE_LSB = 9;

    // Function select field
    localparam int FUNC_W = 3;
    localparam int FUNC_PITCH = 4;
    localparam logic [2:0] FUNC_GPIO = 3'b000;
    localparam logic [2:0] FUNC_ALT_ONE = 3'b001;
    localparam logic [2:0] FUNC_ALT_ZERO = 3'b100;
    localparam logic [2:0] FUNC_ALT_TWO = 3'b101;
    localparam logic [31:0] FUNC_MASK = 32'h7777_7777;
    localparam logic [31:0] FUNC3_MASK = 32'h0000_0077;

    // Timer capture select: two pin indices
    localparam int CAP_W = 5;
    localparam int CAP_A_LSB = 0;
    localparam int CAP_B_LSB = 8;
    localparam logic [31:0] CAP_MASK = 32'h0000_1F1F;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// [rtl/gpm_port.sv]
// GPIO port with pin mux, pin interrupts and AXI4-Lite register slave
//
// Contract
// - Reset: inputs, pull on, IO9-11 up, IO12-13 none
// - Function reset puts IO9, IO10 in alt one
// - All pin drivers off during reset
// - Sleep and standby: all drivers off
// - Wakeup pins IO9-11 keep pull-up in low power; here only where the wake_src bit is set
// - Data drives GPIO outputs; reads return pin levels
// - Direction bit: 0 input, 1 output; reset zero
// - Pull enable per pin; reset low 26 set
// - Drive strength per pin: 0 low, 1 high
// - Sense selects edge or level detection
// - Both-edges selects single or both edges
// - Polarity: falling/low at 0, rising/high at 1
// - Mask bit 1 lets interrupt through
// - Read-only masked interrupt status per pin
// - Write one clears pending interrupt
// - Three-bit function select, IO0-7 first register
// - IO16-23 third register, IO24-25 fourth
// - Bit-set register sets data of GPIO pins
// - Bit-clear register clears data of GPIO pins
// - Capture select routes pins to timer captures
// - Registers decoded at offsets from fixed base
// - Detection only on GPIO pins, from pin level
// - Masked interrupts combined onto one line
// - IO12, IO13 never driven in GPIO function
//
// The AXI4-Lite slave port was left to the implementer.
`default_nettype none
module gpm_port #(
    parameter int NPIN = 26,
    parameter logic [31:0] BASE_ADDR = gpm_pkg::GPM_BASE_ADDR
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NPIN-1:0] pin_in,
    output logic [NPIN-1:0] pin_out,
    output logic [NPIN-1:0] pin_oe,
    output logic [NPIN-1:0] pull_en,
    output logic [NPIN-1:0] pull_up,
    output logic [NPIN-1:0] drive_high,
    output logic [NPIN*3-1:0] pin_func,
    input wire logic [NPIN-1:0] periph_out,
    input wire logic [NPIN-1:0] periph_oe,
    input wire logic low_power,
    input wire logic [2:0] wake_src,
    output logic irq,
    output logic [1:0] timer_capture
);
    import gpm_pkg::*;

    localparam logic [31:0] PMASK = 32'((64'd1 << NPIN) - 64'd1);

    // Bus side state
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] awaddr_q, wdata_q, rdata_q;
    logic [3:0] wstrb_q;

    // Software registers, stored masked so unused bits stay zero
    logic [31:0] data_q, dir_q, pull_q, drive_q, sense_q, both_q, pol_q, mask_q;
    logic [31:0] func0_q, func1_q, func2_q, func3_q, cap_q;
    logic [NPIN-1:0] pend_q, prev_q;

    // Registered pin side outputs
    logic [NPIN-1:0] out_q, oe_q, pull_en_q, pull_up_q, drive_hi_q;
    logic [NPIN*3-1:0] fsel_q;
    logic irq_q;
    logic [1:0] capt_q;

    // Write decode
    wire wr_go = ~awready_q & ~wready_q & ~bvalid_q;
    wire wr_hit = awaddr_q[31:8] == BASE_ADDR[31:8];
    wire [7:0] wr_off = {awaddr_q[7:2], 2'b00};
    wire [31:0] smask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire [31:0] wbits = wdata_q & smask;
    wire we_data = wr_go & wr_hit & (wr_off == OFF_DATA);
    wire we_dir = wr_go & wr_hit & (wr_off == OFF_DIR);
    wire we_pull = wr_go & wr_hit & (wr_off == OFF_PULL);
    wire we_drive = wr_go & wr_hit & (wr_off == OFF_DRIVE);
    wire we_sense = wr_go & wr_hit & (wr_off == OFF_SENSE);
    wire we_both = wr_go & wr_hit & (wr_off == OFF_BOTH);
    wire we_pol = wr_go & wr_hit & (wr_off == OFF_POL);
    wire we_mask = wr_go & wr_hit & (wr_off == OFF_MASK);
    wire we_iclr = wr_go & wr_hit & (wr_off == OFF_ICLR);
    wire we_f0 = wr_go & wr_hit & (wr_off == OFF_FUNC0);
    wire we_f1 = wr_go & wr_hit & (wr_off == OFF_FUNC1);
    wire we_f2 = wr_go & wr_hit & (wr_off == OFF_FUNC2);
    wire we_f3 = wr_go & wr_hit & (wr_off == OFF_FUNC3);
    wire we_set = wr_go & wr_hit & (wr_off == OFF_SET);
    wire we_clr = wr_go & wr_hit & (wr_off == OFF_CLR);
    wire we_cap = wr_go & wr_hit & (wr_off == OFF_CAP);
    wire wr_known = we_data | we_dir | we_pull | we_drive | we_sense | we_both | we_pol | we_mask
        | we_iclr | we_f0 | we_f1 | we_f2 | we_f3 | we_set | we_clr | we_cap
        | (wr_off == OFF_MIS) | (wr_off == OFF_GAP);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m, input logic [31:0] keep);
        merge = ((old & ~m) | (nw & m)) & keep;
    endfunction

    // Per-pin function and GPIO view
    wire [127:0] func_all = {func3_q, func2_q, func1_q, func0_q};
    logic [NPIN*3-1:0] fsel;
    logic [NPIN-1:0] gpio;
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            assign fsel[gi*FUNC_W +: FUNC_W] = func_all[gi*FUNC_PITCH +: FUNC_W];
            assign gpio[gi] = func_all[gi*FUNC_PITCH +: FUNC_W] == FUNC_GPIO;
        end
    endgenerate

    // Interrupt detection
    wire [NPIN-1:0] pol = pol_q[NPIN-1:0];
    wire [NPIN-1:0] both = both_q[NPIN-1:0];
    wire [NPIN-1:0] rise = pin_in & ~prev_q;
    wire [NPIN-1:0] fall = ~pin_in & prev_q;
    wire [NPIN-1:0] edge_evt = (both & (rise | fall)) | (~both & ((pol & rise) | (~pol & fall)));
    wire [NPIN-1:0] lvl_evt = (pol & pin_in) | (~pol & ~pin_in);
    wire [NPIN-1:0] sense = sense_q[NPIN-1:0];
    wire [NPIN-1:0] evt = gpio & ((sense & lvl_evt) | (~sense & edge_evt));
    wire [NPIN-1:0] clr_bits = we_iclr ? wbits[NPIN-1:0] : '0;
    // Set wins over a clear landing in the same cycle
    wire [NPIN-1:0] pend_d = (pend_q & ~clr_bits) | evt;
    wire [NPIN-1:0] masked = pend_q & mask_q[NPIN-1:0];

    // Pin drive decisions
    wire [NPIN-1:0] in_only = INPUT_ONLY_PINS[NPIN-1:0];
    wire [NPIN-1:0] gpio_oe = gpio & dir_q[NPIN-1:0] & ~in_only;
    wire [NPIN-1:0] oe_d = low_power ? '0 : (gpio_oe | (~gpio & periph_oe));
    wire [NPIN-1:0] out_d = (gpio & data_q[NPIN-1:0]) | (~gpio & periph_out);
    wire [31:0] wake_mask = 32'(wake_src) << WAKE_LSB;
    wire [NPIN-1:0] pull_d = low_power ? wake_mask[NPIN-1:0]
                                       : pull_q[NPIN-1:0] & ~NO_PULL_PINS[NPIN-1:0];
    wire [31:0] pin32 = 32'(pin_in);
    wire [1:0] capt_d = {pin32[cap_q[CAP_B_LSB +: CAP_W]], pin32[cap_q[CAP_A_LSB +: CAP_W]]};

    // Read decode
    wire ar_hit = s_axi_araddr[31:8] == BASE_ADDR[31:8];
    wire [7:0] rd_off = {s_axi_araddr[7:2], 2'b00};
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb begin
        rd_ok = ar_hit;
        if (rd_off == OFF_DATA) begin
            rd_mux = pin32;
        end else if (rd_off == OFF_DIR) begin
            rd_mux = dir_q;
        end else if (rd_off == OFF_PULL) begin
            rd_mux = pull_q;
        end else if (rd_off == OFF_DRIVE) begin
            rd_mux = drive_q;
        end else if (rd_off == OFF_SENSE) begin
            rd_mux = sense_q;
        end else if (rd_off == OFF_BOTH) begin
            rd_mux = both_q;
        end else if (rd_off == OFF_POL) begin
            rd_mux = pol_q;
        end else if (rd_off == OFF_MASK) begin
            rd_mux = mask_q;
        end else if (rd_off == OFF_MIS) begin
            rd_mux = 32'(masked);
        end else if (rd_off == OFF_FUNC0) begin
            rd_mux = func0_q;
        end else if (rd_off == OFF_FUNC1) begin
            rd_mux = func1_q;
        end else if (rd_off == OFF_FUNC2) begin
            rd_mux = func2_q;
        end else if (rd_off == OFF_FUNC3) begin
            rd_mux = func3_q;
        end else if (rd_off == OFF_CAP) begin
            rd_mux = cap_q;
        end else if (rd_off == OFF_GAP || rd_off == OFF_ICLR || rd_off == OFF_SET || rd_off == OFF_CLR) begin
            rd_mux = '0;
        end else begin
            rd_mux = '0;
            rd_ok = 1'b0;
        end
    end

    // AXI write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                awready_q <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= (wr_hit && wr_known) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // AXI read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_ok ? rd_mux : '0;
            rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // Register file; masks keep unimplemented and reserved bits at zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_q <= RST_ZERO;
            dir_q <= RST_ZERO;
            pull_q <= RST_PULL;
            drive_q <= RST_ZERO;
            sense_q <= RST_ZERO;
            both_q <= RST_ZERO;
            pol_q <= RST_ZERO;
            mask_q <= RST_ZERO;
            func0_q <= RST_ZERO;
            func1_q <= RST_FUNC1;
            func2_q <= RST_ZERO;
            func3_q <= RST_ZERO;
            cap_q <= RST_ZERO;
        end else begin
            if (we_data) begin
                data_q <= merge(data_q, wdata_q, smask, PMASK);
            end else if (we_set) begin
                data_q <= data_q | (wbits & 32'(gpio));
            end else if (we_clr) begin
                data_q <= data_q & ~(wbits & 32'(gpio));
            end
            if (we_dir) dir_q <= merge(dir_q, wdata_q, smask, PMASK);
            if (we_pull) pull_q <= merge(pull_q, wdata_q, smask, PMASK);
            if (we_drive) drive_q <= merge(drive_q, wdata_q, smask, PMASK);
            if (we_sense) sense_q <= merge(sense_q, wdata_q, smask, PMASK);
            if (we_both) both_q <= merge(both_q, wdata_q, smask, PMASK);
            if (we_pol) pol_q <= merge(pol_q, wdata_q, smask, PMASK);
            if (we_mask) mask_q <= merge(mask_q, wdata_q, smask, PMASK);
            if (we_f0) func0_q <= merge(func0_q, wdata_q, smask, FUNC_MASK);
            if (we_f1) func1_q <= merge(func1_q, wdata_q, smask, FUNC_MASK);
            if (we_f2) func2_q <= merge(func2_q, wdata_q, smask, FUNC_MASK);
            if (we_f3) func3_q <= merge(func3_q, wdata_q, smask, FUNC3_MASK);
            if (we_cap) cap_q <= merge(cap_q, wdata_q, smask, CAP_MASK);
        end
    end

    // Interrupt state and registered pin outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= '0;
            prev_q <= '0;
            irq_q <= 1'b0;
            oe_q <= '0;
            out_q <= '0;
            pull_en_q <= RST_PULL[NPIN-1:0] & ~NO_PULL_PINS[NPIN-1:0];
            pull_up_q <= PULL_UP_PINS[NPIN-1:0];
            drive_hi_q <= '0;
            fsel_q <= '0;
            capt_q <= '0;
        end else begin
            pend_q <= pend_d;
            prev_q <= pin_in;
            irq_q <= |masked;
            oe_q <= oe_d;
            out_q <= out_d;
            pull_en_q <= pull_d;
            pull_up_q <= PULL_UP_PINS[NPIN-1:0];
            drive_hi_q <= drive_q[NPIN-1:0];
            fsel_q <= fsel;
            capt_q <= capt_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign pin_out = out_q;
    assign pin_oe = oe_q;
    assign pull_en = pull_en_q;
    assign pull_up = pull_up_q;
    assign drive_high = drive_hi_q;
    assign pin_func = fsel_q;
    assign irq = irq_q;
    assign timer_capture = capt_q;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_aw_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_clear_write;
        we_iclr;
    endsequence

    a_reset_hiz: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> pin_oe == '0)
        else $error("pin driver on after reset edge");
    a_lowpow_hiz: assert property (low_power |=> pin_oe == '0)
        else $error("pin driven in low power");
    a_wake_pullup: assert property (low_power && wake_src[0] |=> pull_en[WAKE_LSB] && pull_up[WAKE_LSB])
        else $error("wakeup pin lost pull-up");
    a_input_only: assert property (gpio[12] || gpio[13] |=> (pin_oe & $past(gpio) & in_only) == '0)
        else $error("input-only pin driven");
    a_gpio_drive: assert property (!low_power |=> ((pin_oe ^ $past(gpio_oe)) & $past(gpio)) == '0)
        else $error("gpio drive mismatch");
    a_irq_merge: assert property (##1 irq == $past(|(pend_q & mask_q[NPIN-1:0])))
        else $error("irq line mismatch");
    a_clear_w1c: assert property (s_clear_write |=> (pend_q & $past(clr_bits & ~evt)) == '0)
        else $error("pending bit not cleared");
    a_event_sets: assert property (##1 ($past(evt) & ~pend_q) == '0)
        else $error("event lost");
    a_set_bits: assert property (we_set |=> ($past(wbits & 32'(gpio)) & ~data_q) == '0)
        else $error("bit set failed");
    a_write_resp: assert property (s_aw_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response late");
    a_func_reset: assert property ($rose(aresetn) |-> func1_q == RST_FUNC1)
        else $error("function reset wrong");
    a_clr_bits: assert property (we_clr |=> ($past(wbits & 32'(gpio)) & data_q) == '0)
        else $error("bit clear failed");
    a_drive_copy: assert property (##1 drive_high == $past(drive_q[NPIN-1:0]))
        else $error("drive strength mismatch");
endmodule
`default_nettype wire

// [sim/gpio_port_with_pin_mux_bench.sv]
// Self-checking bench for the GPIO port: register bus, pins, interrupts, capture select
`default_nettype none
module gpio_port_with_pin_mux_bench;
    import gpm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] B = GPM_BASE_ADDR;
    localparam logic [25:0] ALL = 26'h3FF_FFFF;
    localparam logic [25:0] EXT = 26'h000_3600;
    // Bits: expected status after the quiet step, sense, both, polarity, quiet level
    localparam logic [4:0] MODES[5] = '{5'b00001, 5'b00010, 5'b10100, 5'b01001, 5'b01010};
    logic aclk = 0;
    logic aresetn = 0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, timer_capture;
    logic [25:0] pin_in, pin_out, pin_oe, pull_en, pull_up, drive_high;
    logic [25:0] ext_val = '0, ext_en = '0, periph_out = '0, periph_oe = '0;
    logic [77:0] pin_func;
    logic low_power = 0;
    logic [2:0] wake_src = '0;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int bad_count = 0;
    int checks = 0;

    always #4 aclk = ~aclk;

    gpm_port i_gpm_port (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .pull_en, .pull_up, .drive_high,
        .pin_func, .periph_out, .periph_oe, .low_power, .wake_src, .irq, .timer_capture);

    gpm_pin_model i_gpm_pin_model (.aclk, .pin_out, .pin_oe, .pull_en, .pull_up, .ext_val,
        .ext_en, .pin_in);

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Address and data are offered together; each is dropped at the edge that takes it
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY,
                      input logic [3:0] st = 4'hF);
        bit aw_ok = 0;
        bit w_ok = 0;
        @(posedge aclk);
        bq.push_back(er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            aw_ok |= s_axi_awvalid & s_axi_awready;
            w_ok |= s_axi_wvalid & s_axi_wready;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        rq.push_back({er, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 0;
    endtask

    task automatic settle();
        repeat (3) @(posedge aclk);
        #1;
    endtask

    // Answers are compared against the oldest note as they appear on the bus
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            check(s_axi_bresp, bq.pop_front());
    end

    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        end_sim();
    end

    initial begin
        logic [31:0] v;
        logic [31:0] e;
        logic [31:0] s;
        logic [31:0] c;
        logic [4:0] md;
        logic [25:0] drv;
        void'($urandom(32'h1307));
        repeat (2) @(posedge aclk);
        check(pin_oe, 26'h0);
        aresetn <= 1;
        settle();
        check(pin_oe, 26'h0);
        check(pull_en, ALL & ~26'h3000);
        check(pull_up, PULL_UP_PINS[25:0]);
        check(pin_func[32:27], 6'b001_001);
        for (int o = 4; o <= 32'h44; o += 4)
            rd(B + o, o == 8 ? RST_PULL : (o == 32'h30 ? RST_FUNC1 : RST_ZERO));
        for (int o = 4; o <= 32'h1C; o += 4) begin
            v = $urandom;
            wr(B + o, v);
            rd(B + o, v & 32'h03FF_FFFF);
            settle();
            if (o == 8)
                check(pull_en, v[25:0] & ~26'h3000);
            if (o == 12)
                check(drive_high, v[25:0]);
        end
        // Only the strobed byte lane may change
        wr(B + OFF_DRIVE, 0);
        wr(B + OFF_DRIVE, 32'hFFFF_FFFF, RESP_OKAY, 4'h2);
        rd(B + OFF_DRIVE, 32'h0000_FF00);
        wr(B + OFF_MASK, 0);
        wr(B + OFF_FUNC0, 32'hFFFF_FFFF);
        rd(B + OFF_FUNC0, FUNC_MASK);
        wr(B + OFF_FUNC3, 32'hFFFF_FFFF);
        rd(B + OFF_FUNC3, FUNC3_MASK);
        settle();
        check(pin_func[2:0], 3'b111);
        check(pin_func[77:72], 6'h3F);
        for (int m = 0; m < 5; m++) begin
            c = {8{1'b0, m == 1 ? FUNC_ALT_ONE : m == 2 ? FUNC_ALT_ZERO : m == 3 ? FUNC_ALT_TWO : FUNC_GPIO}};
            wr(B + OFF_FUNC2, c);
            settle();
            check(pin_func[71:48], {c[30:28], c[26:24], c[22:20], c[18:16], c[14:12], c[10:8], c[6:4], c[2:0]});
        end
        wr(B + OFF_FUNC0, 0);
        wr(B + OFF_FUNC3, 0);
        e = $urandom;
        @(posedge aclk);
        ext_en <= EXT;
        ext_val <= e[25:0];
        periph_out <= ~e[25:0];
        drv = ALL & ~EXT;
        v = $urandom;
        wr(B + OFF_DIR, ALL);
        wr(B + OFF_DATA, v);
        settle();
        check(pin_oe, drv);
        check(pin_out & drv, v[25:0] & drv);
        rd(B + OFF_DATA, {6'h0, (v[25:0] & drv) | (e[25:0] & EXT)});
        s = $urandom;
        c = $urandom;
        wr(B + OFF_SET, s);
        wr(B + OFF_CLR, c);
        settle();
        check(pin_out & drv, (v[25:0] | s[25:0]) & ~c[25:0] & drv);
        @(posedge aclk);
        low_power <= 1;
        // Alternate-function drivers on IO9, IO10 must be forced off as well
        periph_oe <= EXT;
        wake_src <= 3'b101;
        settle();
        check(pin_oe, 26'h0);
        check(pull_en, 26'h0A00);
        check(pull_up & 26'h0A00, 26'h0A00);
        @(posedge aclk);
        low_power <= 0;
        periph_oe <= '0;
        wake_src <= 3'b000;
        ext_en <= ALL;
        ext_val <= '0;
        wr(B + OFF_DIR, 0);
        for (int m = 0; m < 5; m++) begin
            md = MODES[m];
            wr(B + OFF_MASK, 0);
            wr(B + OFF_SENSE, {28'h0, md[3], 3'h0});
            wr(B + OFF_BOTH, {28'h0, md[2], 3'h0});
            wr(B + OFF_POL, {28'h0, md[1], 3'h0});
            wr(B + OFF_ICLR, ALL);
            @(posedge aclk);
            ext_val <= {22'h0, md[0], 3'h0};
            settle();
            if (md[3])
                wr(B + OFF_ICLR, ALL);
            wr(B + OFF_MASK, 32'h8);
            rd(B + OFF_MIS, md[4] ? 32'h8 : 32'h0);
            wr(B + OFF_ICLR, 32'h8);
            @(posedge aclk);
            ext_val <= {22'h0, ~md[0], 3'h0};
            settle();
            check(irq, 1'b1);
            rd(B + OFF_MIS, 32'h8);
            wr(B + OFF_ICLR, 32'h8);
            rd(B + OFF_MIS, md[3] ? 32'h8 : 32'h0);
            wr(B + OFF_MASK, 0);
            settle();
            check(irq, 1'b0);
        end
        // High-level sense on pin 3 still holds, so only the function select keeps it quiet
        wr(B + OFF_FUNC0, 32'h0000_1000);
        wr(B + OFF_ICLR, ALL);
        wr(B + OFF_MASK, 32'h8);
        settle();
        rd(B + OFF_MIS, 0);
        check(irq, 1'b0);
        @(posedge aclk);
        ext_val <= 26'h000_1000;
        wr(B + OFF_CAP, 32'h0000_0C03);
        settle();
        check(timer_capture, 2'b10);
        wr(B + OFF_MIS, ALL);
        rd(B + OFF_MIS, 0);
        wr(B + 32'h48, 32'h1, RESP_SLVERR);
        rd(B + 32'h48, 0, RESP_SLVERR);
        wr(32'h5000_0004, 32'h1, RESP_SLVERR);
        rd(32'h5000_0000, 0, RESP_SLVERR);
        rd(B + OFF_DIR, 0);
        repeat (4) @(posedge aclk);
        end_sim();
    end
endmodule
`default_nettype wire

// [sim/gpm_pin_model.sv]
// Pad-side model: resolves every pin level from the port, outside drivers and pulls
`default_nettype none
module gpm_pin_model #(
    parameter int NPIN = 26
) (
    input wire logic aclk,
    input wire logic [NPIN-1:0] pin_out,
    input wire logic [NPIN-1:0] pin_oe,
    input wire logic [NPIN-1:0] pull_en,
    input wire logic [NPIN-1:0] pull_up,
    input wire logic [NPIN-1:0] ext_val,
    input wire logic [NPIN-1:0] ext_en,
    output logic [NPIN-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NPIN-1:0] float_q = '0;
    // A floating pad toggles every cycle so a stale level never passes for a real one
    always @(posedge aclk) float_q <= ~float_q;
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pull_en[i])
                pin_in[i] = pull_up[i];
            else
                pin_in[i] = float_q[i];
        end
    end
endmodule
`default_nettype wire
